// *** rtl/ptrg_pkg.sv ***
// Purpose: shared constants and types of the pulse train ramp generator
// Assumes: 40 MHz pclk, 32-bit APB register words
// Notes: every offset, bit position and cycle count lives here; reset values too, except those of the emitted and irq status registers
package ptrg_pkg;

	// clock and rate figures
	localparam int unsigned CLK_HZ   = 40_000_000;
	localparam logic [25:0] HALF_CLK = 26'(CLK_HZ / 2);
	localparam logic [31:0] HZ_MAX   = 32'h0003_0d40;
	localparam int          HZ_W     = 18;
	localparam int          FRAC_W   = 16;
	localparam int          ACC_W    = 25;
	localparam logic [4:0]  DIV_STEPS = 5'h10;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_BEGIN_HZ  = 8'h04;
	localparam logic [7:0] OFS_END_HZ    = 8'h08;
	localparam logic [7:0] OFS_PLAT_HZ   = 8'h0c;
	localparam logic [7:0] OFS_UP_CNT    = 8'h10;
	localparam logic [7:0] OFS_DOWN_CNT  = 8'h14;
	localparam logic [7:0] OFS_TRAIN_LEN = 8'h18;
	localparam logic [7:0] OFS_EMITTED   = 8'h1c;
	localparam logic [7:0] OFS_STATUS    = 8'h20;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h24;
	localparam logic [7:0] OFS_IRQ_MASK  = 8'h28;

	// control register bits
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP  = 1;
	localparam int CTRL_SOFT  = 2;
	localparam int CTRL_SHAPE = 3;
	localparam int CTRL_W     = 4;

	// status register: flags in [8:0], channel mode in [13:12]
	localparam int STAT_MODE_LSB = 12;

	// interrupt status bits
	localparam int IRQ_DONE    = 0;
	localparam int IRQ_REFUSED = 1;
	localparam int IRQ_HALTED  = 2;
	localparam int IRQ_W       = 3;

	// reset values
	localparam logic [3:0]  CTRL_RST = 4'h0;
	localparam logic [31:0] HZ_RST   = 32'h0000_0001;
	localparam logic [31:0] CNT_RST  = 32'h0000_0000;
	localparam logic [31:0] LEN_RST  = 32'h0000_0001;
	localparam logic [2:0]  MASK_RST = 3'h0;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_UP   = 2'b01,
		PH_PLAT = 2'b11,
		PH_DOWN = 2'b10
	} ptrg_phase_t;

	typedef enum logic [1:0] {
		MODE_DIGITAL     = 2'h0,
		MODE_PWM         = 2'h1,
		MODE_PULSE_TRAIN = 2'h2
	} ptrg_mode_t;

	typedef struct packed {
		logic [HZ_W-1:0] from_hz;
		logic [HZ_W-1:0] to_hz;
		logic [31:0]     len;
	} ptrg_seg_t;

	typedef struct packed {
		logic error;
		logic bad_chan;
		logic bad_count_flag;
		logic bad_rate_flag;
		logic done;
		logic ramp_down;
		logic plateau;
		logic ramp_up;
		logic running;
	} ptrg_stat_t;

endpackage

// *** rtl/ptrg_top.sv ***
// Purpose: APB-controlled 50% duty pulse train with trapezoid or S ramps
// Assumes: chan_mode and chan_bound come from logic on pclk
// Notes: per-pulse frequency from an NCO; ramp fraction by a serial divider
// Functional notes
// - every pulse is 50% duty; only the frequency changes between pulses
// - shape bit clear gives linear ramps, set gives S-curve ramps
// - ramp-up and ramp-down each last exactly their configured pulse counts
// - a 32-bit readable counter holds pulses emitted in the current train
// - a train starts only on a rising edge of the start bit
// - a stop rising edge ends the train at once, no ramp
// - a soft stop rising edge begins an orderly wind-down
// - soft stop ramps the rate down along the selected shape
// - running flag is high exactly while pulses are emitted
// - three phase flags report ramp-up, plateau and ramp-down
// - done flag sets once the whole train has been emitted or a soft stop has ended it
// - bad rate flag shows any frequency outside its range
// - parameters are checked continuously; status flags always current
// - error when no channel is bound or it is not in pulse train mode
// - channel configured mode is readable and read-only
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module ptrg_top (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     ce,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [1:0]               chan_mode,
	input  wire logic                     chan_bound,
	output logic                          pulse_out,
	output logic                          irq
);

	// frequency range check; low bound is 0 or 1 Hz
	function automatic logic rate_ok(input logic [31:0] hz, input logic need_one);
		rate_ok = (hz <= ptrg_pkg::HZ_MAX) && (!need_one || hz != 32'h0);
	endfunction

	logic [ptrg_pkg::CTRL_W-1:0]    ctrl_r;
	logic [2:0]                     cmd_prev_r;
	logic [31:0]                    begin_hz_r;
	logic [31:0]                    end_hz_r;
	logic [31:0]                    plat_hz_r;
	logic [31:0]                    up_cnt_r;
	logic [31:0]                    down_cnt_r;
	logic [31:0]                    train_len_r;
	logic [31:0]                    emitted_r;
	logic [ptrg_pkg::IRQ_W-1:0]     irq_stat_r;
	logic [ptrg_pkg::IRQ_W-1:0]     irq_mask_r;
	logic [31:0]                    prdata_r;
	ptrg_pkg::ptrg_phase_t          phase_r;
	ptrg_pkg::ptrg_phase_t          phase_nxt;
	ptrg_pkg::ptrg_seg_t            seg_r;
	ptrg_pkg::ptrg_seg_t            seg_nxt;
	logic [31:0]                    k_r;
	logic [31:0]                    k_nxt;
	logic [ptrg_pkg::HZ_W-1:0]      cur_hz_r;
	logic [ptrg_pkg::HZ_W-1:0]      cur_hz_nxt;
	logic                           soft_r;
	logic                           soft_nxt;
	logic                           done_r;
	logic                           fin;
	logic                           halted;
	logic                           launch;
	logic                           refused;
	logic [ptrg_pkg::ACC_W-1:0]     acc_r;
	logic                           out_r;
	logic                           div_busy_r;
	logic [4:0]                     div_cnt_r;
	logic [32:0]                    div_rem_r;
	logic [ptrg_pkg::FRAC_W-1:0]    div_q_r;

	// apb decode
	wire       apb_acc   = psel && penable;
	wire       apb_wr    = apb_acc && pwrite;
	wire       apb_setup = psel && !penable;
	wire [7:0] addr      = paddr;
	wire       hit_ctrl  = addr == ptrg_pkg::OFS_CTRL;
	wire       hit_begin = addr == ptrg_pkg::OFS_BEGIN_HZ;
	wire       hit_end   = addr == ptrg_pkg::OFS_END_HZ;
	wire       hit_plat  = addr == ptrg_pkg::OFS_PLAT_HZ;
	wire       hit_up    = addr == ptrg_pkg::OFS_UP_CNT;
	wire       hit_down  = addr == ptrg_pkg::OFS_DOWN_CNT;
	wire       hit_len   = addr == ptrg_pkg::OFS_TRAIN_LEN;
	wire       hit_emit  = addr == ptrg_pkg::OFS_EMITTED;
	wire       hit_stat  = addr == ptrg_pkg::OFS_STATUS;
	wire       hit_istat = addr == ptrg_pkg::OFS_IRQ_STAT;
	wire       hit_imask = addr == ptrg_pkg::OFS_IRQ_MASK;
	wire       mapped    = hit_ctrl || hit_begin || hit_end || hit_plat || hit_up || hit_down
	                       || hit_len || hit_emit || hit_stat || hit_istat || hit_imask;

	// command edges against last cycle's copy
	wire start_edge = ctrl_r[ptrg_pkg::CTRL_START] && !cmd_prev_r[0];
	wire stop_edge  = ctrl_r[ptrg_pkg::CTRL_STOP] && !cmd_prev_r[1];
	wire soft_edge  = ctrl_r[ptrg_pkg::CTRL_SOFT] && !cmd_prev_r[2];
	wire s_shape    = ctrl_r[ptrg_pkg::CTRL_SHAPE];

	// live parameter checks
	wire        bad_rate_flag  = !rate_ok(begin_hz_r, 1'b0) || !rate_ok(end_hz_r, 1'b0)
	                             || !rate_ok(plat_hz_r, 1'b1);
	wire [32:0] ramp_sum       = {1'b0, up_cnt_r} + {1'b0, down_cnt_r};
	wire        bad_count_flag = (train_len_r == 32'h0)
	                             || (ramp_sum >= {1'b0, train_len_r});
	wire        bad_chan       = !chan_bound
	                             || (chan_mode != ptrg_pkg::MODE_PULSE_TRAIN);
	wire        params_bad     = bad_rate_flag || bad_count_flag || bad_chan;
	wire        running        = phase_r != ptrg_pkg::PH_IDLE;

	// nco: a toggle each half period, so high and low halves match
	wire [ptrg_pkg::HZ_W-1:0]  eff_hz   = (cur_hz_r == '0) ? ptrg_pkg::HZ_W'(1) : cur_hz_r;
	wire [25:0]                acc_sum  = {1'b0, acc_r} + {8'h00, eff_hz};
	wire                       tick     = running && (acc_sum >= ptrg_pkg::HALF_CLK);
	wire [25:0]                acc_sub  = acc_sum - ptrg_pkg::HALF_CLK;
	wire [ptrg_pkg::ACC_W-1:0] acc_nxt  = tick ? acc_sub[ptrg_pkg::ACC_W-1:0]
	                                           : acc_sum[ptrg_pkg::ACC_W-1:0];
	wire                       pulse_begin = tick && !out_r;
	wire                       pulse_end   = tick && out_r;

	wire [31:0] k_inc       = k_r + 32'h1;
	wire [31:0] emitted_inc = emitted_r + 32'h1;
	wire [31:0] down_at     = train_len_r - down_cnt_r;
	wire        into_down   = emitted_inc >= down_at;
	wire        seg_over    = k_inc >= seg_r.len;
	wire        is_ramp     = (phase_r == ptrg_pkg::PH_UP) || (phase_r == ptrg_pkg::PH_DOWN);

	// ramp shaping: x = k/len, s = 3x^2 - 2x^3
	wire [31:0]                  sq      = 32'(div_q_r) * 32'(div_q_r);
	wire [15:0]                  x2      = sq[31:16];
	wire [31:0]                  cu      = 32'(x2) * 32'(div_q_r);
	wire [15:0]                  x3      = cu[31:16];
	wire [17:0]                  s_val   = 18'(3) * {2'b00, x2} - {1'b0, x3, 1'b0};
	wire [16:0]                  frac    = s_shape ? s_val[16:0] : {1'b0, div_q_r};
	wire signed [18:0]           delta   = $signed({1'b0, seg_r.to_hz}) - $signed({1'b0, seg_r.from_hz});
	wire signed [36:0]           prod    = 37'(delta) * $signed({20'h0, frac});
	wire signed [36:0]           step    = prod >>> ptrg_pkg::FRAC_W;
	wire [18:0]                  f_wide  = {1'b0, seg_r.from_hz} + step[18:0];
	wire [ptrg_pkg::HZ_W-1:0]    f_calc  = f_wide[ptrg_pkg::HZ_W-1:0];

	// divider step: one quotient bit per cycle
	wire [32:0] div_sh  = {div_rem_r[31:0], 1'b0};
	wire        div_ge  = div_sh >= {1'b0, seg_r.len};
	wire [32:0] div_sub = div_sh - {1'b0, seg_r.len};

	// train sequencing
	always_comb begin
		phase_nxt  = phase_r;
		seg_nxt    = seg_r;
		k_nxt      = k_r;
		cur_hz_nxt = cur_hz_r;
		soft_nxt   = soft_r || (soft_edge && running);
		fin        = 1'b0;
		halted     = 1'b0;
		launch     = 1'b0;
		refused    = 1'b0;
		if (stop_edge && running) begin
			phase_nxt = ptrg_pkg::PH_IDLE;
			soft_nxt  = 1'b0;
			halted    = 1'b1;
		end else if (!running) begin
			soft_nxt = 1'b0;
			if (start_edge) begin
				if (params_bad) begin
					refused = 1'b1;
				end else begin
					launch = 1'b1;
					k_nxt  = 32'h0;
					if (up_cnt_r != 32'h0) begin
						phase_nxt  = ptrg_pkg::PH_UP;
						seg_nxt    = '{begin_hz_r[ptrg_pkg::HZ_W-1:0], plat_hz_r[ptrg_pkg::HZ_W-1:0],
						               up_cnt_r};
						cur_hz_nxt = begin_hz_r[ptrg_pkg::HZ_W-1:0];
					end else begin
						phase_nxt  = ptrg_pkg::PH_PLAT;
						seg_nxt    = '{plat_hz_r[ptrg_pkg::HZ_W-1:0], plat_hz_r[ptrg_pkg::HZ_W-1:0], 32'h0};
						cur_hz_nxt = plat_hz_r[ptrg_pkg::HZ_W-1:0];
					end
				end
			end
		end else if (pulse_end) begin
			k_nxt      = k_inc;
			cur_hz_nxt = (phase_r == ptrg_pkg::PH_PLAT) ? cur_hz_r : f_calc;
			if (emitted_inc == train_len_r || (phase_r == ptrg_pkg::PH_DOWN && soft_r && seg_over)) begin
				fin = 1'b1;
			end else if (soft_r && phase_r != ptrg_pkg::PH_DOWN) begin
				if (down_cnt_r == 32'h0) begin
					fin = 1'b1;
				end else begin
					phase_nxt  = ptrg_pkg::PH_DOWN;
					seg_nxt    = '{cur_hz_r, end_hz_r[ptrg_pkg::HZ_W-1:0], down_cnt_r};
					k_nxt      = 32'h0;
					cur_hz_nxt = cur_hz_r;
				end
			end else if ((phase_r == ptrg_pkg::PH_UP && seg_over) || (phase_r == ptrg_pkg::PH_PLAT && into_down)) begin
				k_nxt      = 32'h0;
				cur_hz_nxt = plat_hz_r[ptrg_pkg::HZ_W-1:0];
				if (into_down) begin
					phase_nxt = ptrg_pkg::PH_DOWN;
					seg_nxt   = '{plat_hz_r[ptrg_pkg::HZ_W-1:0], end_hz_r[ptrg_pkg::HZ_W-1:0], down_cnt_r};
				end else begin
					phase_nxt = ptrg_pkg::PH_PLAT;
					seg_nxt   = '{plat_hz_r[ptrg_pkg::HZ_W-1:0], plat_hz_r[ptrg_pkg::HZ_W-1:0], 32'h0};
				end
			end
			if (fin) begin
				phase_nxt = ptrg_pkg::PH_IDLE;
				soft_nxt  = 1'b0;
			end
		end
	end

	// status word
	ptrg_pkg::ptrg_stat_t stat;
	assign stat.running        = running;
	assign stat.ramp_up        = phase_r == ptrg_pkg::PH_UP;
	assign stat.plateau        = phase_r == ptrg_pkg::PH_PLAT;
	assign stat.ramp_down      = phase_r == ptrg_pkg::PH_DOWN;
	assign stat.done           = done_r;
	assign stat.bad_rate_flag  = bad_rate_flag;
	assign stat.bad_count_flag = bad_count_flag;
	assign stat.bad_chan       = bad_chan;
	assign stat.error          = params_bad;

	wire [31:0] stat_word = {18'h0, chan_mode, 3'h0, stat};
	wire [31:0] rd_word   = hit_ctrl  ? {28'h0, ctrl_r} :
	                        hit_begin ? begin_hz_r :
	                        hit_end   ? end_hz_r :
	                        hit_plat  ? plat_hz_r :
	                        hit_up    ? up_cnt_r :
	                        hit_down  ? down_cnt_r :
	                        hit_len   ? train_len_r :
	                        hit_emit  ? emitted_r :
	                        hit_stat  ? stat_word :
	                        hit_istat ? {29'h0, irq_stat_r} :
	                        hit_imask ? {29'h0, irq_mask_r} : 32'h0;

	wire [ptrg_pkg::IRQ_W-1:0] irq_evt = {halted, refused, fin};
	wire [ptrg_pkg::IRQ_W-1:0] irq_clr = (apb_wr && hit_istat) ? pwdata[ptrg_pkg::IRQ_W-1:0] : '0;

	assign prdata    = prdata_r;
	assign pready    = 1'b1;
	assign pslverr   = apb_acc && !mapped;
	assign pulse_out = out_r;
	assign irq       = |(irq_stat_r & irq_mask_r);

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r      <= ptrg_pkg::CTRL_RST;
			cmd_prev_r  <= 3'h0;
			begin_hz_r  <= ptrg_pkg::HZ_RST;
			end_hz_r    <= ptrg_pkg::HZ_RST;
			plat_hz_r   <= ptrg_pkg::HZ_RST;
			up_cnt_r    <= ptrg_pkg::CNT_RST;
			down_cnt_r  <= ptrg_pkg::CNT_RST;
			train_len_r <= ptrg_pkg::LEN_RST;
			irq_mask_r  <= ptrg_pkg::MASK_RST;
			irq_stat_r  <= '0;
			prdata_r    <= 32'h0;
		end else if (ce) begin
			cmd_prev_r <= ctrl_r[2:0];
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt; // set beats clear
			if (apb_setup && !pwrite) begin
				prdata_r <= rd_word;
			end
			if (apb_wr && hit_ctrl) begin
				ctrl_r <= pwdata[ptrg_pkg::CTRL_W-1:0];
			end
			if (apb_wr && hit_begin) begin
				begin_hz_r <= pwdata;
			end
			if (apb_wr && hit_end) begin
				end_hz_r <= pwdata;
			end
			if (apb_wr && hit_plat) begin
				plat_hz_r <= pwdata;
			end
			if (apb_wr && hit_up) begin
				up_cnt_r <= pwdata;
			end
			if (apb_wr && hit_down) begin
				down_cnt_r <= pwdata;
			end
			if (apb_wr && hit_len) begin
				train_len_r <= pwdata;
			end
			if (apb_wr && hit_imask) begin
				irq_mask_r <= pwdata[ptrg_pkg::IRQ_W-1:0];
			end
		end
	end

	// train state and pulse engine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r   <= ptrg_pkg::PH_IDLE;
			seg_r     <= '0;
			k_r       <= 32'h0;
			cur_hz_r  <= '0;
			soft_r    <= 1'b0;
			done_r    <= 1'b0;
			emitted_r <= 32'h0;
			acc_r     <= '0;
			out_r     <= 1'b0;
		end else if (ce) begin
			phase_r  <= phase_nxt;
			seg_r    <= seg_nxt;
			k_r      <= k_nxt;
			cur_hz_r <= cur_hz_nxt;
			soft_r   <= soft_nxt;
			if (launch) begin
				emitted_r <= 32'h0;
				done_r    <= 1'b0;
			end else begin
				if (pulse_end) begin
					emitted_r <= emitted_inc;
				end
				if (fin) begin
					done_r <= 1'b1;
				end
			end
			if (!running || phase_nxt == ptrg_pkg::PH_IDLE) begin
				acc_r <= '0;
				out_r <= 1'b0;
			end else begin
				acc_r <= acc_nxt;
				out_r <= out_r ^ tick;
			end
		end
	end

	// fraction of the next pulse, worked out during the current high half
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_busy_r <= 1'b0;
			div_cnt_r  <= 5'h0;
			div_rem_r  <= 33'h0;
			div_q_r    <= '0;
		end else if (ce) begin
			if (pulse_begin && is_ramp) begin
				div_busy_r <= 1'b1;
				div_cnt_r  <= 5'h0;
				div_rem_r  <= {1'b0, k_inc};
				div_q_r    <= '0;
			end else if (div_busy_r) begin
				div_rem_r  <= div_ge ? div_sub : div_sh;
				div_q_r    <= {div_q_r[ptrg_pkg::FRAC_W-2:0], div_ge};
				div_cnt_r  <= div_cnt_r + 5'h1;
				div_busy_r <= (div_cnt_r + 5'h1) != ptrg_pkg::DIV_STEPS;
			end
		end
	end

endmodule // ptrg_top

// *** dv/ptrg_props.sv ***
// Purpose: port-level assertions for the pulse train generator
// Assumes: bound into ptrg_top, ce high while commands are issued
// Notes: rate registers and the stop bit are shadowed from apb writes
`timescale 1ns/1ps
module ptrg_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [1:0]  chan_mode,
	input wire logic        chan_bound,
	input wire logic        pulse_out,
	input wire logic        irq
);
	logic [31:0] bhz_r, ehz_r, phz_r;
	logic        stop_r;
	wire         wr_w     = psel && penable && pwrite && ce;
	wire         rd_st    = psel && penable && !pwrite && paddr == ptrg_pkg::OFS_STATUS;
	wire         mapped   = paddr[1:0] == 2'h0 && paddr <= ptrg_pkg::OFS_IRQ_MASK;
	wire         chan_bad = !chan_bound || chan_mode != 2'h2;
	wire         hz_bad   = bhz_r > ptrg_pkg::HZ_MAX || ehz_r > ptrg_pkg::HZ_MAX || phz_r == 32'h0
		|| phz_r > ptrg_pkg::HZ_MAX;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bhz_r  <= ptrg_pkg::HZ_RST;
			ehz_r  <= ptrg_pkg::HZ_RST;
			phz_r  <= ptrg_pkg::HZ_RST;
			stop_r <= 1'b0;
		end else if (wr_w) begin
			if (paddr == ptrg_pkg::OFS_BEGIN_HZ) bhz_r <= pwdata;
			if (paddr == ptrg_pkg::OFS_END_HZ) ehz_r <= pwdata;
			if (paddr == ptrg_pkg::OFS_PLAT_HZ) phz_r <= pwdata;
			if (paddr == ptrg_pkg::OFS_CTRL) stop_r <= pwdata[1];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ready; pready; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_unmapped; psel && penable |-> pslverr == !mapped && (mapped || pwrite || prdata == 32'h0); endproperty
	a_unmapped: assert property (p_unmapped) else $error("bad unmapped answer");
	property p_rsvd; rd_st |-> prdata[31:14] == 18'h0 && prdata[11:9] == 3'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
	property p_mode; rd_st |-> prdata[13:12] == $past(chan_mode); endproperty
	a_mode: assert property (p_mode) else $error("mode field wrong");
	property p_chan; rd_st |-> prdata[7] == $past(chan_bad) && prdata[8] == |prdata[7:5]; endproperty
	a_chan: assert property (p_chan) else $error("channel error wrong");
	property p_rate; rd_st && $past(hz_bad, 2) == $past(hz_bad) |-> prdata[5] == $past(hz_bad); endproperty
	a_rate: assert property (p_rate) else $error("rate flag wrong");
	property p_phase; rd_st |-> $onehot0(prdata[3:1]) && prdata[0] == |prdata[3:1]; endproperty
	a_phase: assert property (p_phase) else $error("phase flags wrong");
	property p_done; rd_st && prdata[0] |-> !prdata[4]; endproperty
	a_done: assert property (p_done) else $error("done while running");
	property p_stop; wr_w && paddr == ptrg_pkg::OFS_CTRL && pwdata[1] && !stop_r |-> ##3 (!pulse_out)[*4]; endproperty
	a_stop: assert property (p_stop) else $error("pulse after stop");
endmodule // ptrg_props
bind ptrg_top ptrg_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.chan_mode(chan_mode), .chan_bound(chan_bound), .pulse_out(pulse_out), .irq(irq));

// *** dv/ptrg_drive_model.sv ***
// Purpose: stepper drive model counting pulses and timing their halves
// Assumes: pulse is a low half then a high half ending in a fall
// Notes: clr restarts counts; first pulse low half is not compared
`timescale 1ns/1ps
module ptrg_drive_model (
	input  wire logic        pclk,
	input  wire logic        clr,
	input  wire logic        step_in,
	output logic      [31:0] steps,
	output logic      [31:0] duty_bad
);
	logic [31:0] hi_w [0:63];
	logic [31:0] run_c, lo_c;
	logic        prev;
	always @(posedge pclk) begin
		prev <= step_in;
		if (clr) begin
			steps    <= 32'h0;
			duty_bad <= 32'h0;
			run_c    <= 32'h0;
		end else if (step_in != prev) begin
			run_c <= 32'h1;
			if (!step_in) begin
				if (steps < 64) hi_w[steps[5:0]] <= run_c;
				if (steps != 0 && (run_c > lo_c + 4 || lo_c > run_c + 4)) duty_bad <= duty_bad + 1;
				steps <= steps + 1;
			end else lo_c <= run_c;
		end else run_c <= run_c + 1;
	end
endmodule // ptrg_drive_model

// *** dv/tb_top.sv ***
// Purpose: self-checking bench for the pulse train generator
// Assumes: 40 MHz pclk, ce high except in the freeze test, drive model on pulse_out
// Notes: plateau of 200 kHz gives 100-cycle halves
`timescale 1ns/1ps
module tb_top;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, pulse_out, irq, clr, bound, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, n0, lin1, steps, dbad;
	logic [1:0]  cmode;
	int          error_cnt, cmp_count;
	logic [31:0] rv [11] = '{32'h0, 32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h1, 32'h0, 32'h2000, 32'h0, 32'h0};
	logic [7:0]  ea [6] = '{8'h0c, 8'h0c, 8'h04, 8'h08, 8'h18, 8'h10};
	logic [31:0] eb [6] = '{32'h0, 32'h3_0d41, 32'h3_0d41, 32'h0, 32'h0, 32'h3e5};
	logic [31:0] eg [6] = '{32'h3_0d40, 32'h3_0d40, 32'h1_86a0, 32'h1_86a0, 32'h3e8, 32'h2};
	logic [31:0] ee [6] = '{32'h120, 32'h120, 32'h120, 32'h0, 32'h140, 32'h140};
	ptrg_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_mode(cmode),
		.chan_bound(bound), .pulse_out(pulse_out), .irq(irq));
	ptrg_drive_model drv (.pclk(pclk), .clr(clr), .step_in(pulse_out), .steps(steps), .duty_bad(dbad));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic tmo(input string s);
		error_cnt++;
		$display("CHECK FAILED %s exp done got timeout", s);
		give_verdict;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) tmo("pready");
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (2) @(posedge pclk);
	endtask
	task automatic rc(input string s, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, e, q & m);
	endtask
	task automatic go(input logic [31:0] d);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		wr(ptrg_pkg::OFS_CTRL, d);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			apb(1'b0, ptrg_pkg::OFS_STATUS, 32'h0);
			n++;
		end while (q[0] !== 1'b0 && n < 2000);
		if (n >= 2000) tmo("idle");
	endtask
	task automatic wait_steps(input int k);
		int n;
		for (n = 0; n < 20000 && steps < k; n++) @(posedge pclk);
		if (n >= 20000) tmo("steps");
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		{ce, clr, bound, cmode, error_cnt, cmp_count} = {1'b1, 1'b1, 1'b1, 2'h2, 64'h0};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 11; i++) rc("reset value", 8'(i * 4), 32'hffff_ffff, rv[i]);
		apb(1'b0, 8'h2c, 32'h0);
		chk("unmapped data", 32'h0, q);
		chk("unmapped error", 32'h1, {31'h0, err});
		wr(ptrg_pkg::OFS_EMITTED, 32'hffff_ffff);
		rc("emitted ro", ptrg_pkg::OFS_EMITTED, 32'hffff_ffff, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 7; i++) wr(8'(4 + i * 4), i < 2 ? 32'h1_86a0 : i == 2 ? 32'h3_0d40 : i == 5 ? 32'hc :
			i == 6 ? 32'h0 : 32'h4);
		wr(ptrg_pkg::OFS_IRQ_MASK, 32'h1);
		go(32'h1);
		wait_idle;
		rc("emitted", ptrg_pkg::OFS_EMITTED, 32'hffff_ffff, 32'hc);
		rc("status end", ptrg_pkg::OFS_STATUS, 32'h1f, 32'h10);
		chk("steps", 32'hc, steps);
		chk("duty", 32'h0, dbad);
		chk("up last", 32'h1, drv.hi_w[3] > 105);
		chk("plateau first", 32'h1, drv.hi_w[4] < 103);
		chk("down first", 32'h1, drv.hi_w[8] < 103);
		chk("down second", 32'h1, drv.hi_w[9] > 105);
		chk("irq done", 32'h1, irq);
		lin1 = drv.hi_w[1];
		wr(ptrg_pkg::OFS_IRQ_STAT, 32'h1);
		chk("irq cleared", 32'h0, irq);
		$display("test linear done");
		wr(ptrg_pkg::OFS_CTRL, 32'h0);
		go(32'h9);
		wait_idle;
		chk("s curve", 32'h1, drv.hi_w[1] > lin1 + 5);
		chk("s duty", 32'h0, dbad);
		n0 = steps;
		wr(ptrg_pkg::OFS_CTRL, 32'h9);
		repeat (400) @(posedge pclk);
		chk("level start", n0, steps);
		$display("test s curve done");
		wr(ptrg_pkg::OFS_CTRL, 32'h0);
		wr(ptrg_pkg::OFS_TRAIN_LEN, 32'h3e8);
		go(32'h1);
		rc("emitted cleared", ptrg_pkg::OFS_EMITTED, 32'hffff_ffff, 32'h0);
		rc("done cleared", ptrg_pkg::OFS_STATUS, 32'h11, 32'h1);
		wait_steps(6);
		// clock enable low must freeze the running train
		ce <= 1'b0;
		repeat (2) @(posedge pclk);
		n0 = steps;
		repeat (300) @(posedge pclk);
		chk("ce freeze", n0, steps);
		ce <= 1'b1;
		@(posedge pclk);
		wr(ptrg_pkg::OFS_CTRL, 32'h3);
		rc("stopped", ptrg_pkg::OFS_STATUS, 32'h1f, 32'h0);
		rc("halt irq", ptrg_pkg::OFS_IRQ_STAT, 32'h4, 32'h4);
		n0 = steps;
		repeat (300) @(posedge pclk);
		chk("no pulses", n0, steps);
		$display("test stop done");
		wr(ptrg_pkg::OFS_CTRL, 32'h0);
		wr(ptrg_pkg::OFS_UP_CNT, 32'h2);
		wr(ptrg_pkg::OFS_DOWN_CNT, 32'h3);
		go(32'h1);
		wait_steps(6);
		n0 = steps;
		wr(ptrg_pkg::OFS_CTRL, 32'h5);
		wait_idle;
		chk("soft length", 32'h1, steps - n0 < 6 && steps - n0 > 2);
		chk("soft slows", 32'h1, drv.hi_w[steps[5:0] - 6'h1] > 130);
		rc("soft emitted", ptrg_pkg::OFS_EMITTED, 32'hffff_ffff, steps);
		$display("test soft stop done");
		wr(ptrg_pkg::OFS_CTRL, 32'h0);
		wr(ptrg_pkg::OFS_IRQ_STAT, 32'h7);
		for (int i = 0; i < 6; i++) begin
			wr(ea[i], eb[i]);
			rc("param flags", ptrg_pkg::OFS_STATUS, 32'h1e0, ee[i]);
			wr(ea[i], eg[i]);
		end
		bound <= 1'b0;
		wr(ptrg_pkg::OFS_CTRL, 32'h1);
		rc("no channel", ptrg_pkg::OFS_STATUS, 32'h1e1, 32'h180);
		rc("refused", ptrg_pkg::OFS_IRQ_STAT, 32'h7, 32'h2);
		chk("masked irq", 32'h0, irq);
		bound <= 1'b1;
		cmode <= 2'h1;
		rc("mode", ptrg_pkg::OFS_STATUS, 32'h31e1, 32'h1180);
		cmode <= 2'h2;
		$display("test errors done");
		// reset in mid-train must silence the output and restore defaults
		wr(ptrg_pkg::OFS_CTRL, 32'h0);
		go(32'h1);
		wait_steps(2);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		n0 = steps;
		chk("reset pulse", 32'h0, {31'h0, pulse_out});
		rc("reset status", ptrg_pkg::OFS_STATUS, 32'hffff_ffff, 32'h2000);
		repeat (300) @(posedge pclk);
		chk("reset quiet", n0, steps);
		$display("test reset done");
		give_verdict;
	end
endmodule // tb_top
